// >>> hw/thsa_nv_store.sv
// Nonvolatile store for high limit, low limit and configuration
`timescale 1ns/1ps
`default_nettype none
module thsa_nv_store
  import thsa_pkg::*;
(
  input wire logic core_clk,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:2];

  // Contents survive reset; factory defaults at start
  initial begin
    mem[NV_HIGH] = NV_HIGH_DEFAULT;
    mem[NV_LOW] = NV_LOW_DEFAULT;
    mem[NV_CFG] = NV_CFG_DEFAULT;
  end

  // Write port
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge core_clk) begin
    rdata <= mem[raddr];
  end
endmodule // thsa_nv_store
`default_nettype wire

// >>> hw/thsa_pkg.sv
// Package of constants and types for the thermometer scratchpad and alarm
// Behaviour
// R1: Alarm compares only result bits 11..4 against the 8-bit limits.
// R2: Alarm sets when temperature <= low limit or > high limit.
// R3: Alarm flag re-evaluated after every conversion; clears once condition ends.
// R4: Alarm search lets only devices with alarm set take part.
// R5: Master should reconvert after changing limits while an alarm stands.
// R6: Parasite master enables strong pull-up within 10 us after convert/copy.
// R7: Strong pull-up held for conversion time or 10 ms write time.
// R8: Master makes no other bus traffic while strong pull-up is on.
// R9: After power query, parasite device answers low, external device high.
// R10: Master supplies strong pull-up during conversions if query answered low.
// R11: Identity code: family byte low, 48-bit serial, CRC of 56 bits on top.
// R12: Bytes 0 and 1 present result low and high, read-only.
// R13: Bytes 2, 3 hold high and low limits; byte 4 holds configuration.
// R14: Bytes 5 to 7 ignore writes and read as all ones.
// R15: Byte 8 is read-only CRC over bytes 0 to 7.
// R16: Write-scratchpad data fills bytes 2, 3, 4 in order.
// R17: Read-scratchpad returns contents starting from byte 0.
// R18: Copy stores high limit, low limit and configuration into nonvolatile store.
// R19: After power-up, nonvolatile values load into their scratchpad bytes.
// R20: Recall reloads from nonvolatile store; slots read 0 busy, 1 done.
// R21: Both resolution bits power up as one, giving 12-bit resolution.
// R22: Configuration bit 7 and bits 0..4 ignore writes, read as ones.
// R23: Result held as 16-bit sign-extended two's complement, four fraction bits.
// R24: Lower resolutions leave lowest fraction bits undefined.
// R25: Result resets to 0550h, the plus 85 degree encoding.
// R26: CRCs use x^8+x^5+x^4+1, zero start, least significant bit first.
// R27: Limits are signed two's complement during comparison.
// R28: Byte 8 recomputed whenever any of bytes 0 to 7 changes.
package thsa_pkg;
  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_WRITE_SP = 8'h4e;
  localparam logic [7:0] CMD_READ_SP = 8'hbe;
  localparam logic [7:0] CMD_COPY = 8'h48;
  localparam logic [7:0] CMD_RECALL = 8'hb8;
  localparam logic [7:0] CMD_POWER = 8'hb4;
  localparam logic [7:0] ROM_ALARM_SEARCH = 8'hec;
  localparam logic [7:0] ROM_SEARCH = 8'hf0;
  // ---------------------------------------------------------------
  // Scratchpad layout
  // ---------------------------------------------------------------
  localparam logic [3:0] SP_TEMP_LOW = 4'h0;
  localparam logic [3:0] SP_TEMP_HIGH = 4'h1;
  localparam logic [3:0] SP_HIGH_LIMIT = 4'h2;
  localparam logic [3:0] SP_LOW_LIMIT = 4'h3;
  localparam logic [3:0] SP_CONFIG = 4'h4;
  localparam logic [3:0] SP_CHECK = 4'h8;
  localparam logic [7:0] SP_RSVD_VALUE = 8'hff;
  localparam logic [15:0] TEMP_RESET = 16'h0550;
  localparam int TEMP_CMP_MSB = 11;
  localparam int TEMP_CMP_LSB = 4;
  localparam logic [7:0] CFG_RSVD_MASK = 8'h9f;
  localparam int CFG_RES_HIGH_BIT = 6;
  localparam int CFG_RES_LOW_BIT = 5;
  // ---------------------------------------------------------------
  // Nonvolatile store
  // ---------------------------------------------------------------
  localparam logic [1:0] NV_HIGH = 2'h0;
  localparam logic [1:0] NV_LOW = 2'h1;
  localparam logic [1:0] NV_CFG = 2'h2;
  localparam logic [7:0] NV_HIGH_DEFAULT = 8'h4b;
  localparam logic [7:0] NV_LOW_DEFAULT = 8'h46;
  localparam logic [7:0] NV_CFG_DEFAULT = 8'hff;
  // ---------------------------------------------------------------
  // Identity code and CRC
  // ---------------------------------------------------------------
  localparam logic [7:0] ROM_FAMILY = 8'h3c; // Arbitrary value
  localparam logic [47:0] ROM_SERIAL = 48'h0000_1234_5678; // Arbitrary
  localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int NV_WRITE_TIME_US = 10000;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_FREQ_KHZ / 1000;
  localparam int WAIT_W = 20;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } thsa_cmd_t;
  typedef struct packed {
    logic done;
    logic [15:0] value;
  } thsa_conv_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_COPY = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_LOAD = 4'b1000
  } thsa_state_t;
  // One byte into the reflected CRC, least significant bit first
  function automatic logic [7:0] thsa_crc8(input logic [7:0] crc_in,
                                           input logic [7:0] data);
    logic [7:0] c;
    logic fb;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ data[i];
      c = c >> 1;
      if (fb) begin
        c = c ^ CRC_POLY_REFL;
      end
    end
    return c;
  endfunction
endpackage

// >>> hw/thsa_top.sv
// Scratchpad, nonvolatile backing and alarm logic of the thermometer
`timescale 1ns/1ps
`default_nettype none
module thsa_top
  import thsa_pkg::*;
#(
  parameter int NV_WRITE_CYC = NV_WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire thsa_cmd_t func_cmd,
  input wire thsa_cmd_t rom_cmd,
  input wire thsa_cmd_t wr_byte,
  input wire logic rd_req,
  input wire logic parasite_pin,
  input wire thsa_conv_t conv,
  output logic cmd_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic slot_bit,
  output logic alarm_flag,
  output logic search_active,
  output logic conv_start,
  output logic [1:0] res_sel,
  output logic [63:0] rom_id
);
  // ---------------------------------------------------------------
  // Identity code
  // ---------------------------------------------------------------
  function automatic logic [7:0] rom_crc(input logic [55:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 7; i++) begin
      c = thsa_crc8(c, d[i*8 +: 8]);
    end
    return c;
  endfunction
  localparam logic [55:0] ROM_BODY = {ROM_SERIAL, ROM_FAMILY};
  assign rom_id = {rom_crc(ROM_BODY), ROM_BODY}; // [R11] [R26]

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  thsa_state_t state;
  logic [15:0] temp_result;
  logic [7:0] high_alarm_limit;
  logic [7:0] low_alarm_limit;
  logic res_sel_high;
  logic res_sel_low;
  logic [7:0] scratchpad_check;
  logic [1:0] idx;
  logic [1:0] wr_idx;
  logic [3:0] rd_idx;
  logic [WAIT_W-1:0] wait_cnt;
  logic ld_valid;
  logic [1:0] ld_idx;
  logic conv_busy;
  logic last_power;
  logic nv_we;
  logic [7:0] nv_rdata;
  logic [7:0] nv_wdata;
  logic [2:0] pin_sync;
  logic parasite;
  logic cmd_take;

  // Configuration byte as read, reserved bits forced to one
  function automatic logic [7:0] cfg_byte(input logic hi, input logic lo);
    logic [7:0] b;
    b = CFG_RSVD_MASK;
    b[CFG_RES_HIGH_BIT] = hi;
    b[CFG_RES_LOW_BIT] = lo;
    return b;
  endfunction

  // Scratchpad byte selection
  function automatic logic [7:0] sp_byte(input logic [3:0] i,
                                         input logic [15:0] t,
                                         input logic [7:0] th,
                                         input logic [7:0] tl,
                                         input logic [7:0] cfg,
                                         input logic [7:0] chk);
    logic [7:0] b;
    case (i)
      SP_TEMP_LOW: b = t[7:0]; // [R12]
      SP_TEMP_HIGH: b = t[15:8]; // [R12]
      SP_HIGH_LIMIT: b = th; // [R13]
      SP_LOW_LIMIT: b = tl; // [R13]
      SP_CONFIG: b = cfg; // [R13]
      SP_CHECK: b = chk; // [R15]
      default: b = SP_RSVD_VALUE; // [R14]
    endcase
    return b;
  endfunction

  // Alarm condition on the integer part, limits signed
  function automatic logic alarm_cond(input logic [15:0] t,
                                      input logic [7:0] th,
                                      input logic [7:0] tl);
    logic signed [7:0] tv;
    tv = signed'(t[TEMP_CMP_MSB:TEMP_CMP_LSB]); // [R1]
    return (tv <= signed'(tl)) || (tv > signed'(th)); // [R2] [R27]
  endfunction

  logic [7:0] cfg_now;
  assign cfg_now = cfg_byte(res_sel_high, res_sel_low); // [R22]
  assign res_sel = {res_sel_high, res_sel_low}; // [R21]

  // ---------------------------------------------------------------
  // Strap synchroniser for the power mode pin
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_sync <= 3'h0;
      parasite <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], parasite_pin};
      if (pin_sync[1] == pin_sync[2]) begin
        parasite <= pin_sync[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Command acceptance
  // ---------------------------------------------------------------
  assign cmd_ready = (state == ST_IDLE) && !ld_valid;
  assign cmd_take = func_cmd.valid && cmd_ready;

  // Conversion request and busy tracking
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conv_start <= 1'b0;
      conv_busy <= 1'b0;
    end else begin
      conv_start <= cmd_take && (func_cmd.code == CMD_CONVERT);
      // A new start beats a finishing result in the same cycle
      if (cmd_take && (func_cmd.code == CMD_CONVERT)) begin
        conv_busy <= 1'b1;
      end else if (conv.done) begin
        conv_busy <= 1'b0;
      end
    end
  end

  // Temperature result and alarm, updated per conversion
  always_ff @(posedge core_clk) begin
    if (rst) begin
      temp_result <= TEMP_RESET; // [R25]
      alarm_flag <= 1'b0;
    end else if (conv.done) begin
      temp_result <= conv.value; // [R23] [R24]
      alarm_flag <= alarm_cond(conv.value, high_alarm_limit,
                               low_alarm_limit); // [R3]
    end
  end

  // Search participation, alarm search only when flagged
  always_ff @(posedge core_clk) begin
    if (rst) begin
      search_active <= 1'b0;
    end else if (rom_cmd.valid) begin
      if (rom_cmd.code == ROM_ALARM_SEARCH) begin
        search_active <= alarm_flag; // [R4]
      end else begin
        search_active <= (rom_cmd.code == ROM_SEARCH);
      end
    end
  end

  // ---------------------------------------------------------------
  // Copy and recall sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_LOAD; // [R19]
      idx <= 2'h0;
      wait_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          idx <= 2'h0;
          if (cmd_take && func_cmd.code == CMD_COPY) begin
            state <= ST_COPY;
          end else if (cmd_take && func_cmd.code == CMD_RECALL) begin
            state <= ST_LOAD; // [R20]
          end
        end
        ST_COPY: begin
          idx <= idx + 2'h1;
          if (idx == NV_CFG) begin
            state <= ST_WAIT;
            wait_cnt <= WAIT_W'(NV_WRITE_CYC - 1);
          end
        end
        ST_WAIT: begin
          wait_cnt <= wait_cnt - 1'b1;
          if (wait_cnt == '0) begin
            state <= ST_IDLE;
          end
        end
        ST_LOAD: begin
          idx <= idx + 2'h1;
          if (idx == NV_CFG) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Store writes, one byte per cycle
  always_comb begin
    nv_we = (state == ST_COPY); // [R18]
    case (idx)
      NV_HIGH: nv_wdata = high_alarm_limit;
      NV_LOW: nv_wdata = low_alarm_limit;
      default: nv_wdata = cfg_now;
    endcase
  end

  thsa_nv_store u_nv (
    .core_clk(core_clk),
    .we(nv_we),
    .waddr(idx),
    .wdata(nv_wdata),
    .raddr(idx),
    .rdata(nv_rdata)
  );

  // Read data arrives one cycle after the address
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ld_valid <= 1'b0;
      ld_idx <= 2'h0;
    end else begin
      ld_valid <= (state == ST_LOAD);
      ld_idx <= idx;
    end
  end

  // ---------------------------------------------------------------
  // Writable scratchpad bytes
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      high_alarm_limit <= NV_HIGH_DEFAULT;
      low_alarm_limit <= NV_LOW_DEFAULT;
      res_sel_high <= 1'b1; // [R21]
      res_sel_low <= 1'b1; // [R21]
      wr_idx <= 2'h3;
    end else begin
      if (cmd_take && func_cmd.code == CMD_WRITE_SP) begin
        wr_idx <= 2'h0; // [R16]
      end else if (wr_byte.valid && wr_idx != 2'h3) begin
        wr_idx <= wr_idx + 2'h1;
        case (wr_idx)
          NV_HIGH: high_alarm_limit <= wr_byte.code; // [R16]
          NV_LOW: low_alarm_limit <= wr_byte.code;
          default: begin
            res_sel_high <= wr_byte.code[CFG_RES_HIGH_BIT]; // [R22]
            res_sel_low <= wr_byte.code[CFG_RES_LOW_BIT];
          end
        endcase
      end
      if (ld_valid) begin
        case (ld_idx)
          NV_HIGH: high_alarm_limit <= nv_rdata; // [R19] [R20]
          NV_LOW: low_alarm_limit <= nv_rdata;
          default: begin
            res_sel_high <= nv_rdata[CFG_RES_HIGH_BIT];
            res_sel_low <= nv_rdata[CFG_RES_LOW_BIT];
          end
        endcase
      end
    end
  end

  // Scratchpad check byte follows every change of bytes 0..7
  logic [7:0] next_check;
  always_comb begin
    next_check = CRC_INIT;
    for (int i = 0; i < 8; i++) begin
      next_check = thsa_crc8(next_check, sp_byte(4'(i), temp_result,
                             high_alarm_limit, low_alarm_limit, cfg_now,
                             8'h00)); // [R26]
    end
  end

  // Tracks through reset too, so no false step after release
  always_ff @(posedge core_clk) begin
    scratchpad_check <= next_check; // [R15] [R28]
  end

  // ---------------------------------------------------------------
  // Read-scratchpad byte stream and slot answer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_idx <= SP_TEMP_LOW;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      last_power <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      if (cmd_take) begin
        last_power <= (func_cmd.code == CMD_POWER);
      end
      if (cmd_take && func_cmd.code == CMD_READ_SP) begin
        rd_idx <= SP_TEMP_LOW; // [R17]
      end else if (rd_req) begin
        rd_data <= sp_byte(rd_idx, temp_result, high_alarm_limit,
                           low_alarm_limit, cfg_now, scratchpad_check);
        if (rd_idx != SP_CHECK + 4'h1) begin
          rd_idx <= rd_idx + 4'h1;
        end
      end
    end
  end

  // Slot answer: power mode, else busy reads as zero
  always_comb begin
    if (last_power) begin
      slot_bit = !parasite; // [R9]
    end else begin
      slot_bit = !((state != ST_IDLE) || ld_valid || conv_busy); // [R20]
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [3:0] rd_idx_q;
  always_ff @(posedge core_clk) begin
    rd_idx_q <= rd_idx;
  end

  property p_alarm_set;
    conv.done && alarm_cond(conv.value, high_alarm_limit, low_alarm_limit)
      |=> alarm_flag;
  endproperty
  a_alarm_set: assert property (p_alarm_set) // [R2]
    else $error("alarm not set on out of range result");

  property p_alarm_clear;
    conv.done && !alarm_cond(conv.value, high_alarm_limit, low_alarm_limit)
      |=> !alarm_flag;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) // [R3]
    else $error("alarm not cleared after in range result");

  property p_alarm_hold;
    !conv.done |=> $stable(alarm_flag);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) // [R3]
    else $error("alarm changed without conversion");

  property p_search;
    rom_cmd.valid && rom_cmd.code == ROM_ALARM_SEARCH
      |=> search_active == $past(alarm_flag);
  endproperty
  a_search: assert property (p_search) // [R4]
    else $error("alarm search participation wrong");

  property p_rsvd;
    rd_valid && rd_idx_q > SP_CONFIG && rd_idx_q < SP_CHECK
      |-> rd_data == SP_RSVD_VALUE;
  endproperty
  a_rsvd: assert property (p_rsvd) // [R14]
    else $error("reserved byte not all ones");

  sequence s_copy_req;
    cmd_take && func_cmd.code == CMD_COPY;
  endsequence
  sequence s_copy_run;
    nv_we [*3] ##1 (state == ST_WAIT);
  endsequence
  property p_copy;
    s_copy_req |=> s_copy_run;
  endproperty
  a_copy: assert property (p_copy) // [R18]
    else $error("copy did not write three bytes");

  property p_recall_slot;
    cmd_take && func_cmd.code == CMD_RECALL
      |=> !slot_bit [*4] ##1 slot_bit;
  endproperty
  a_recall_slot: assert property (p_recall_slot) // [R20]
    else $error("recall slot answer wrong");

  property p_power;
    last_power |-> slot_bit == !parasite;
  endproperty
  a_power: assert property (p_power) // [R9]
    else $error("power query answer wrong");

  property p_cfg_rsvd;
    rd_valid && rd_idx_q == SP_CONFIG
      |-> (rd_data & CFG_RSVD_MASK) == CFG_RSVD_MASK;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) // [R22]
    else $error("reserved configuration bits not one");

  property p_check;
    $stable(temp_result) && $stable(cfg_now) && $stable(high_alarm_limit)
      && $stable(low_alarm_limit) |=> $stable(scratchpad_check);
  endproperty
  a_check: assert property (p_check) // [R28]
    else $error("check byte changed with stable data");
endmodule // thsa_top
`default_nettype wire

// >>> verif/thermo_scratchpad_alarm_test.sv
// Self-checking bench for the scratchpad and alarm block
`timescale 1ns/1ps
`default_nettype none
module thermo_scratchpad_alarm_test
  import thsa_pkg::*;
;
  typedef struct packed {
    logic [7:0] th, tl, cfg;
    logic [15:0] temp;
    logic alarm;
  } thsa_row_t;
  thsa_row_t rows [7] = '{
    '{8'h19, 8'h0a, 8'h00, 16'h0191, 1'b0},
    '{8'h19, 8'h0a, 8'h20, 16'h01a0, 1'b1},
    '{8'h19, 8'h0a, 8'h40, 16'h00a2, 1'b1},
    '{8'h19, 8'h0a, 8'h60, 16'h00b0, 1'b0},
    '{8'h19, 8'hf6, 8'hff, 16'hff5e, 1'b1},
    '{8'h19, 8'hf6, 8'h7f, 16'hff70, 1'b0},
    '{8'h19, 8'hf6, 8'h00, 16'h7190, 1'b0}
  };
  logic core_clk, rst, parasite_pin, rd_req, cmd_ready, rd_valid;
  logic slot_bit, alarm_flag, search_active, conv_start;
  logic [7:0] rd_data, c;
  logic [1:0] res_sel;
  logic [63:0] rom_id;
  thsa_cmd_t func_cmd, rom_cmd, wr_byte;
  thsa_conv_t conv;
  int err_total = 0;
  int comparisons = 0;
  thsa_top #(.NV_WRITE_CYC(20)) thsa_top_inst (.core_clk(core_clk),
    .rst(rst), .func_cmd(func_cmd), .rom_cmd(rom_cmd), .wr_byte(wr_byte),
    .rd_req(rd_req), .parasite_pin(parasite_pin), .conv(conv),
    .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .slot_bit(slot_bit), .alarm_flag(alarm_flag),
    .search_active(search_active), .conv_start(conv_start),
    .res_sel(res_sel), .rom_id(rom_id));
  thsa_master thsa_master_inst (.core_clk(core_clk), .cmd_ready(cmd_ready),
    .conv_start(conv_start), .slot_bit(slot_bit), .rd_valid(rd_valid),
    .rd_data(rd_data), .func_cmd(func_cmd), .rom_cmd(rom_cmd),
    .wr_byte(wr_byte), .rd_req(rd_req), .conv(conv));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 8'h8c : c >> 1;
    return c;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
  endtask
  // Read all nine bytes, check byte computed here
  task automatic check_sp(input logic [15:0] t, input logic [7:0] th,
                          input logic [7:0] tl, input logic [7:0] cfg);
    logic [7:0] exp [9];
    logic [7:0] k, b;
    exp = '{t[7:0], t[15:8], th, tl, cfg | 8'h9f, 8'hff, 8'hff, 8'hff, 8'h00};
    k = 8'h00;
    for (int i = 0; i < 8; i++) k = crc_byte(k, exp[i]);
    exp[8] = k;
    thsa_master_inst.strobe_func(CMD_READ_SP);
    for (int i = 0; i < 9; i++) begin
      thsa_master_inst.read_byte(b);
      check(b, exp[i]);
    end
  endtask
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    test_done();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    parasite_pin = 1'b0;
    do_reset();
    foreach (rows[i]) begin
      thsa_master_inst.strobe_func(CMD_WRITE_SP);
      thsa_master_inst.strobe_wr(rows[i].th);
      thsa_master_inst.strobe_wr(rows[i].tl);
      thsa_master_inst.strobe_wr(rows[i].cfg);
      thsa_master_inst.convert(rows[i].temp);
      check(alarm_flag, rows[i].alarm);
      check(res_sel, rows[i].cfg[6:5]);
      thsa_master_inst.strobe_rom(ROM_ALARM_SEARCH);
      check(search_active, rows[i].alarm);
      check_sp(rows[i].temp, rows[i].th, rows[i].tl, rows[i].cfg);
    end
    check(thsa_master_inst.starts, 7);
    thsa_master_inst.strobe_rom(ROM_SEARCH);
    check(search_active, 1'b1);
    c = 8'h00;
    for (int i = 0; i < 7; i++) begin
      c = crc_byte(c, 8'({ROM_SERIAL, ROM_FAMILY} >> (8 * i)));
    end
    check(rom_id, {c, ROM_SERIAL, ROM_FAMILY});
    // Power source query in both strap settings
    thsa_master_inst.power_query();
    check(slot_bit, 1'b1);
    parasite_pin = 1'b1;
    repeat (5) @(negedge core_clk);
    thsa_master_inst.power_query();
    check(slot_bit, 1'b0);
    // Power-up load of store defaults after a mid-run reset
    do_reset();
    check(alarm_flag, 1'b0);
    check_sp(16'h0550, 8'h4b, 8'h46, 8'hff);
    check(res_sel, 2'b11);
    // Fourth data byte ignored, then copy under strong pull-up
    thsa_master_inst.strobe_func(CMD_WRITE_SP);
    thsa_master_inst.strobe_wr(8'h7d);
    thsa_master_inst.strobe_wr(8'h81);
    thsa_master_inst.strobe_wr(8'h3f);
    thsa_master_inst.strobe_wr(8'h00);
    thsa_master_inst.strobe_func(CMD_COPY);
    check(cmd_ready, 1'b0);
    check(slot_bit, 1'b0);
    check_sp(16'h0550, 8'h7d, 8'h81, 8'h3f);
    // Recall restores the stored copy over fresh data
    thsa_master_inst.strobe_func(CMD_WRITE_SP);
    thsa_master_inst.strobe_wr(8'h01);
    thsa_master_inst.strobe_wr(8'h02);
    thsa_master_inst.strobe_wr(8'h03);
    thsa_master_inst.strobe_func(CMD_RECALL);
    check(slot_bit, 1'b0);
    repeat (8) @(negedge core_clk);
    check(slot_bit, 1'b1);
    check_sp(16'h0550, 8'h7d, 8'h81, 8'h3f);
    do_reset();
    check_sp(16'h0550, 8'h7d, 8'h81, 8'h3f);
    check(res_sel, 2'b01);
    test_done();
  end
endmodule // thermo_scratchpad_alarm_test
`default_nettype wire

// >>> verif/thsa_master.sv
// Bus master model that drives the command side of the scratchpad block
`timescale 1ns/1ps
`default_nettype none
module thsa_master
  import thsa_pkg::*;
(
  input wire logic core_clk,
  input wire logic cmd_ready,
  input wire logic conv_start,
  input wire logic slot_bit,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output var thsa_cmd_t func_cmd,
  output var thsa_cmd_t rom_cmd,
  output var thsa_cmd_t wr_byte,
  output logic rd_req,
  output var thsa_conv_t conv
);
  logic strong_pullup = 1'b0; // Bus held high to feed the device
  logic need_pullup = 1'b0; // Learned from the power query
  int starts = 0;
  // Idle strobes from time zero
  initial begin
    func_cmd = '0;
    rom_cmd = '0;
    wr_byte = '0;
    rd_req = 1'b0;
    conv = '0;
  end
  // Count conversion start pulses
  always @(posedge core_clk) begin
    if (conv_start === 1'b1) begin
      starts <= starts + 1;
    end
  end
  // ---------------------------------------------------------------
  // Bus transfers, each a one-cycle strobe plus a gap
  // ---------------------------------------------------------------
  task automatic strobe_func(input logic [7:0] code);
    int n;
    n = 0;
    // No traffic until the device is idle again or 100 cycles pass
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    strong_pullup = 1'b0;
    func_cmd = {1'b1, code};
    @(negedge core_clk);
    func_cmd = '0;
    strong_pullup = need_pullup &&
      (code == CMD_CONVERT || code == CMD_COPY);
    @(negedge core_clk);
  endtask
  task automatic strobe_rom(input logic [7:0] code);
    rom_cmd = {1'b1, code};
    @(negedge core_clk);
    rom_cmd = '0;
    @(negedge core_clk);
  endtask
  task automatic strobe_wr(input logic [7:0] b);
    wr_byte = {1'b1, b};
    @(negedge core_clk);
    wr_byte = '0;
    @(negedge core_clk);
  endtask
  task automatic read_byte(output logic [7:0] b);
    rd_req = 1'b1;
    @(negedge core_clk);
    rd_req = 1'b0;
    b = (rd_valid === 1'b1) ? rd_data : 8'hxx;
    @(negedge core_clk);
  endtask
  // Conversion: quiet bus for the whole conversion time
  task automatic convert(input logic [15:0] value);
    strobe_func(CMD_CONVERT);
    repeat (6) @(negedge core_clk);
    conv = {1'b1, value};
    @(negedge core_clk);
    conv = '0;
    strong_pullup = 1'b0;
    @(negedge core_clk);
  endtask
  // Power source query decides later pull-up use
  task automatic power_query();
    strobe_rom(8'hcc);
    strobe_func(CMD_POWER);
    need_pullup = (slot_bit === 1'b0);
  endtask
endmodule // thsa_master
`default_nettype wire
